// ### hw/epll_pkg.sv
// Constants and types for the enhanced loop digital control block
package epll_pkg;

   // ----------------------------------------------------------------
   // Counter and chain geometry
   // ----------------------------------------------------------------
   localparam int CNT_W = 9;                 // Holds divide value minus one, 1..512
   localparam int NUM_REG = 2;               // Regional output counters
   localparam int NUM_GLB = 4;               // Global output counters
   localparam int NUM_EXT = 4;               // External output counters
   localparam int NUM_POST = NUM_REG + NUM_GLB + NUM_EXT;
   localparam int DLY_W = 4;                 // Output delay element code
   localparam int CHAIN_LEN = 2 * CNT_W + NUM_POST * (CNT_W + DLY_W);
   localparam int BITCNT_W = 8;

   // Field positions inside the chain (bit 0 is the last bit shifted in)
   localparam int PRE_POS = 0;
   localparam int FB_POS = PRE_POS + CNT_W;
   localparam int POST_POS = FB_POS + CNT_W;
   localparam int DLY_POS = POST_POS + NUM_POST * CNT_W;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [CNT_W-1:0] CNT_RST = 9'h000;   // Divide by one
   localparam logic [DLY_W-1:0] DLY_RST = 4'h0;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_MHZ = 200;
   localparam int SCAN_CLK_MHZ = 25;
   localparam int CFG_TIME_US = 20;
   localparam int RELOCK_TIME_US = 100;
   // Longest time: round down
   localparam int RELOCK_CYCLES = RELOCK_TIME_US * SYS_CLK_MHZ;
   // Chain load time in ns at the documented shift rate
   localparam int CFG_LOAD_NS = (CHAIN_LEN * 1000) / SCAN_CLK_MHZ;
   localparam int SENSE_CYCLES = 64;         // Primary idle cycles before it counts as lost
   localparam int LOCK_COUNT = 8;            // Up compare pulses, error within one, before lock
   localparam int TMR_W = 16;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {SW_RUN, SW_WAIT_LOW} epll_sw_t;

   // Packed so that a cast of the chain places fields at the positions above
   typedef struct packed {
      logic [NUM_POST-1:0][DLY_W-1:0] dly;
      logic [NUM_POST-1:0][CNT_W-1:0] post_m1;
      logic [CNT_W-1:0] fb_m1;
      logic [CNT_W-1:0] pre_m1;
   } epll_cfg_t;

   typedef struct packed {
      epll_cfg_t cfg;
      logic pri_m, pri_s, pri_d;
      logic sec_m, sec_s;
      logic swr_m, swr_s, swr_d;
      logic sck_m, sck_s, sck_d;
      logic sdat_m, sdat_s;
      epll_sw_t sw_state;
      logic sel_sec;
      logic loop_ref;
      logic [TMR_W-1:0] pri_idle;
      logic pri_lost;
      logic [CNT_W-1:0] pre_cnt;
      logic ref_pulse;
      logic [CNT_W-1:0] fb_cnt;
      logic fb_pulse;
      logic pd_up, pd_dn;
      logic signed [3:0] phase_err;
      logic [7:0] lock_cnt;
      logic locked;
      logic relock_run;
      logic [TMR_W-1:0] relock_cnt;
      logic relock_late;
      logic cfg_loaded;
      logic [NUM_POST-1:0][CNT_W-1:0] post_cnt;
      logic [NUM_POST-1:0] post_tick;
      logic [NUM_POST-1:0] post_clk;
   } epll_st_t;

endpackage : epll_pkg

// ### hw/epll_ctrl.sv
// Digital control of the enhanced loop: dividers, reference switchover, reconfiguration chain
`timescale 1ns/1ps
`default_nettype none

module epll_ctrl #(
   parameter int SENSE_CYC = epll_pkg::SENSE_CYCLES,
   parameter int LOCK_CNT = epll_pkg::LOCK_COUNT,
   parameter int RELOCK_CYC = epll_pkg::RELOCK_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Reference clocks and switchover control
   input wire logic primary_ref_clock,
   input wire logic secondary_ref_clock,
   input wire logic auto_switch_en,
   input wire logic switch_req,
   // Oscillator event, one pulse per oscillator cycle
   input wire logic osc_tick,
   // Reconfiguration chain
   input wire logic scan_clk,
   input wire logic scan_data,
   input wire logic scan_clr,
   // Reference and phase detector
   output logic loop_ref,
   output logic ref_sel_secondary,
   output logic switching,
   output logic primary_lost,
   output logic phase_detector_up,
   output logic phase_detector_dn,
   output logic locked,
   output logic relock_late,
   // Active settings
   output logic [epll_pkg::CNT_W-1:0] pre_div_m1,
   output logic [epll_pkg::CNT_W-1:0] fb_mul_m1,
   output logic [epll_pkg::NUM_POST-1:0][epll_pkg::CNT_W-1:0] post_div_m1,
   output logic [epll_pkg::NUM_POST-1:0][epll_pkg::DLY_W-1:0] out_delay,
   output logic cfg_loaded,
   // Post-scale outputs
   output logic [epll_pkg::NUM_POST-1:0] post_tick,
   output logic [epll_pkg::NUM_POST-1:0] post_clk
);
   import epll_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (SENSE_CYC < 2 || SENSE_CYC >= (1 << TMR_W)) begin : g_chk_sense
      $error("SENSE_CYC out of range");
   end
   if (LOCK_CNT < 1 || LOCK_CNT > 255) begin : g_chk_lock
      $error("LOCK_CNT out of range");
   end
   if (RELOCK_CYC < 1 || RELOCK_CYC >= (1 << TMR_W)) begin : g_chk_relock
      $error("RELOCK_CYC out of range");
   end
   if (CFG_LOAD_NS >= CFG_TIME_US * 1000) begin : g_chk_cfg
      $error("Chain too long to reload in time");
   end
   if (CHAIN_LEN >= (1 << BITCNT_W)) begin : g_chk_len
      $error("Bit counter too narrow for chain");
   end

   localparam logic [TMR_W-1:0] SENSE_LIM = TMR_W'(SENSE_CYC);
   localparam logic [TMR_W-1:0] RELOCK_LIM = TMR_W'(RELOCK_CYC - 1);
   localparam logic [7:0] LOCK_LIM = 8'(LOCK_CNT);
   localparam logic [BITCNT_W-1:0] LAST_BIT = BITCNT_W'(CHAIN_LEN - 1);

   localparam epll_cfg_t CFG_RST = '{
      dly: {NUM_POST{DLY_RST}},
      post_m1: {NUM_POST{CNT_RST}},
      fb_m1: CNT_RST,
      pre_m1: CNT_RST
   };

   epll_st_t st_r, st_nxt;

   // ----------------------------------------------------------------
   // Serial chain, kept apart so the clear can act without the clock
   // ----------------------------------------------------------------
   logic [CHAIN_LEN-1:0] chain_r;
   logic [BITCNT_W-1:0] bit_cnt_r;
   logic load_r;
   logic chain_arst_n;
   logic [1:0] clr_hold_r;
   logic chain_rst_n;
   logic scan_edge;

   // Either the block reset or the chain clear empties the shift side
   assign chain_arst_n = arst_n & ~scan_clr;
   assign scan_edge = st_r.sck_s & ~st_r.sck_d;

   // The clear bites at once but lets go only two clock edges later, so that
   // the chain never leaves its clear close to a sampling edge of its own clock
   always_ff @(posedge clk or negedge chain_arst_n) begin
      if (!chain_arst_n) begin
         clr_hold_r <= 2'h0;
      end else begin
         clr_hold_r <= {clr_hold_r[0], 1'b1};
      end
   end
   assign chain_rst_n = clr_hold_r[1];

   // One bit per rising shift edge, newest bit at the bottom
   always_ff @(posedge clk or negedge chain_rst_n) begin
      if (!chain_rst_n) begin
         chain_r <= '0;
         bit_cnt_r <= '0;
         load_r <= 1'b0;
      end else begin
         load_r <= 1'b0;
         if (scan_edge) begin
            chain_r <= {chain_r[CHAIN_LEN-2:0], st_r.sdat_s};
            if (bit_cnt_r == LAST_BIT) begin
               bit_cnt_r <= '0;
               load_r <= 1'b1;
            end else begin
               bit_cnt_r <= bit_cnt_r + 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic pri_rise;
      logic swr_rise;
      logic old_s;
      logic new_s;
      logic ref_rise;
      logic do_switch;
      logic restart_lock;
      logic signed [3:0] err;

      st_nxt = st_r;
      pri_rise = 1'b0;
      swr_rise = 1'b0;
      old_s = 1'b0;
      new_s = 1'b0;
      ref_rise = 1'b0;
      do_switch = 1'b0;
      restart_lock = 1'b0;
      err = '0;

      // Two-stage synchronisers, third stage only for edge finding
      st_nxt.pri_m = primary_ref_clock;
      st_nxt.pri_s = st_r.pri_m;
      st_nxt.pri_d = st_r.pri_s;
      st_nxt.sec_m = secondary_ref_clock;
      st_nxt.sec_s = st_r.sec_m;
      st_nxt.swr_m = switch_req;
      st_nxt.swr_s = st_r.swr_m;
      st_nxt.swr_d = st_r.swr_s;
      st_nxt.sck_m = scan_clk;
      st_nxt.sck_s = st_r.sck_m;
      st_nxt.sck_d = st_r.sck_s;
      st_nxt.sdat_m = scan_data;
      st_nxt.sdat_s = st_r.sdat_m;

      pri_rise = st_r.pri_s & ~st_r.pri_d;
      swr_rise = st_r.swr_s & ~st_r.swr_d;

      // Clock sense: a primary with no edge for too long is lost
      if (pri_rise) begin
         st_nxt.pri_idle = '0;
      end else if (st_r.pri_idle != SENSE_LIM) begin
         st_nxt.pri_idle = st_r.pri_idle + 1'b1;
      end
      st_nxt.pri_lost = (st_nxt.pri_idle == SENSE_LIM);

      // Switchover state machine
      old_s = st_r.sel_sec ? st_r.sec_s : st_r.pri_s;
      new_s = st_r.sel_sec ? st_r.pri_s : st_r.sec_s;
      unique case (st_r.sw_state)
         SW_RUN: begin
            st_nxt.loop_ref = old_s;
            if ((auto_switch_en && !st_r.sel_sec && st_r.pri_lost) || swr_rise) begin
               st_nxt.sw_state = SW_WAIT_LOW;
            end
         end
         SW_WAIT_LOW: begin
            // Let the old high phase finish, then hold low until the new one is low
            // A lost source may sit high; its phase is already long, so cutting is safe
            st_nxt.loop_ref = st_r.loop_ref & old_s & ~st_r.pri_lost;
            if (!st_r.loop_ref && !new_s) begin
               st_nxt.sel_sec = ~st_r.sel_sec;
               st_nxt.sw_state = SW_RUN;
               do_switch = 1'b1;
            end
         end
      endcase

      ref_rise = st_nxt.loop_ref & ~st_r.loop_ref;

      // Pre-scale divider on the loop reference
      st_nxt.ref_pulse = 1'b0;
      if (ref_rise) begin
         if (st_r.pre_cnt >= st_r.cfg.pre_m1) begin
            st_nxt.pre_cnt = '0;
            st_nxt.ref_pulse = 1'b1;
         end else begin
            st_nxt.pre_cnt = st_r.pre_cnt + 1'b1;
         end
      end

      // Feedback divider on the oscillator; the oscillator is never gated
      st_nxt.fb_pulse = 1'b0;
      if (osc_tick) begin
         if (st_r.fb_cnt >= st_r.cfg.fb_m1) begin
            st_nxt.fb_cnt = '0;
            st_nxt.fb_pulse = 1'b1;
         end else begin
            st_nxt.fb_cnt = st_r.fb_cnt + 1'b1;
         end
      end

      // Phase detector: steer oscillator so both divided rates match
      st_nxt.pd_up = st_r.ref_pulse & ~st_r.fb_pulse;
      st_nxt.pd_dn = st_r.fb_pulse & ~st_r.ref_pulse;

      // Lock detect on the running difference of compare pulses
      err = st_r.phase_err;
      if (st_r.pd_up) begin
         err = err + 4'sd1;
      end
      if (st_r.pd_dn) begin
         err = err - 4'sd1;
      end
      restart_lock = do_switch | load_r;
      if (restart_lock || err > 4'sd1 || err < -4'sd1) begin
         st_nxt.phase_err = '0;
         st_nxt.lock_cnt = '0;
         st_nxt.locked = 1'b0;
      end else begin
         st_nxt.phase_err = err;
         if (st_r.pd_up && st_r.lock_cnt != LOCK_LIM) begin
            st_nxt.lock_cnt = st_r.lock_cnt + 1'b1;
         end
         st_nxt.locked = (st_nxt.lock_cnt == LOCK_LIM);
      end

      // Relock watchdog after a reference switch
      if (do_switch) begin
         st_nxt.relock_run = 1'b1;
         st_nxt.relock_cnt = '0;
         st_nxt.relock_late = 1'b0;
      end else if (st_r.relock_run) begin
         if (st_r.locked) begin
            st_nxt.relock_run = 1'b0;
         end else if (st_r.relock_cnt == RELOCK_LIM) begin
            st_nxt.relock_run = 1'b0;
            st_nxt.relock_late = 1'b1;
         end else begin
            st_nxt.relock_cnt = st_r.relock_cnt + 1'b1;
         end
      end
      if (st_r.locked) begin
         st_nxt.relock_late = 1'b0;
      end

      // Chain load replaces counters and delays only
      st_nxt.cfg_loaded = load_r;
      if (load_r) begin
         st_nxt.cfg = epll_cfg_t'(chain_r);
      end

      // Independent post-scale counters, square output high for the first half
      for (int i = 0; i < NUM_POST; i++) begin
         st_nxt.post_tick[i] = 1'b0;
         if (osc_tick) begin
            if (st_r.post_cnt[i] >= st_r.cfg.post_m1[i]) begin
               st_nxt.post_cnt[i] = '0;
               st_nxt.post_tick[i] = 1'b1;
            end else begin
               st_nxt.post_cnt[i] = st_r.post_cnt[i] + 1'b1;
            end
         end
         st_nxt.post_clk[i] = (st_nxt.post_cnt[i] <= (st_r.cfg.post_m1[i] >> 1));
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '{
            cfg: CFG_RST,
            sw_state: SW_RUN,
            default: '0
         };
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ----------------------------------------------------------------
   assign loop_ref = st_r.loop_ref;
   assign ref_sel_secondary = st_r.sel_sec;
   assign switching = (st_r.sw_state == SW_WAIT_LOW);
   assign primary_lost = st_r.pri_lost;
   assign phase_detector_up = st_r.pd_up;
   assign phase_detector_dn = st_r.pd_dn;
   assign locked = st_r.locked;
   assign relock_late = st_r.relock_late;
   assign pre_div_m1 = st_r.cfg.pre_m1;
   assign fb_mul_m1 = st_r.cfg.fb_m1;
   assign post_div_m1 = st_r.cfg.post_m1;
   assign out_delay = st_r.cfg.dly;
   assign cfg_loaded = st_r.cfg_loaded;
   assign post_tick = st_r.post_tick;
   assign post_clk = st_r.post_clk;

endmodule : epll_ctrl

`default_nettype wire

// ### tb/epll_scan_src.sv
// Shift-chain source model standing in for the fabric logic
`timescale 1ns/1ps
`default_nettype none
module epll_scan_src (
   // Frame request
   input wire logic go,
   input wire logic [epll_pkg::CHAIN_LEN-1:0] word,
   input wire logic [7:0] nbits,
   // Chain pins
   output logic scan_clk,
   output logic scan_data,
   output logic busy
);
   import epll_pkg::*;
   // Shift clock stands low between frames; top bit goes first so it ends at the chain top
   initial begin
      scan_clk = 1'b0;
      scan_data = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge go);
         busy = 1'b1;
         for (int i = CHAIN_LEN - 1; i >= CHAIN_LEN - int'(nbits); i--) begin
            scan_data = word[i];
            #16 scan_clk = 1'b1;
            #32 scan_clk = 1'b0;
            #16;
         end
         // Released data shows the inverse, so a stale bit can never pass for a good one
         scan_data = ~scan_data;
         busy = 1'b0;
      end
   end
endmodule : epll_scan_src
`default_nettype wire

// ### tb/epll_ctrl_asserts.sv
// Port checker for the enhanced loop control block
`timescale 1ns/1ps
`default_nettype none
module epll_ctrl_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Watched ports
   input wire logic auto_switch_en,
   input wire logic scan_clr,
   input wire logic loop_ref,
   input wire logic ref_sel_secondary,
   input wire logic switching,
   input wire logic primary_lost,
   input wire logic locked,
   input wire logic relock_late,
   input wire logic [epll_pkg::CNT_W-1:0] pre_div_m1,
   input wire logic [epll_pkg::CNT_W-1:0] fb_mul_m1,
   input wire logic cfg_loaded
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   // Switchover: select moves only as a switch ends, output never rises mid-switch
   AST_SEL_AT_END: assert property ($changed(ref_sel_secondary) |-> $fell(switching))
      else $error("reference select moved outside a switch end");
   AST_NO_GLITCH: assert property (switching && $past(switching) |-> !$rose(loop_ref))
      else $error("loop reference rose during a switch");
   AST_SW_BOUND: assert property ($rose(switching) |-> ##[1:200] !switching)
      else $error("switch did not finish");
   AST_AUTO: assert property (auto_switch_en && primary_lost && !ref_sel_secondary && !switching
      |-> ##[0:2] switching)
      else $error("lost primary did not start a switch");
   AST_SW_UNLOCK: assert property ($fell(switching) |-> !locked)
      else $error("lock kept across a switch");
   AST_LATE_UNLOCKED: assert property (locked && $past(locked) |-> !relock_late)
      else $error("late flag while locked");
   // Chain: settings move only with the one-cycle load pulse, never while cleared
   AST_CFG_ONE: assert property (cfg_loaded |=> !cfg_loaded)
      else $error("load pulse longer than one cycle");
   AST_CFG_ONLY_LOAD: assert property ($changed(pre_div_m1) || $changed(fb_mul_m1) |-> cfg_loaded)
      else $error("settings changed without a load");
   AST_CLR_BLOCKS: assert property (scan_clr && $past(scan_clr) |-> !cfg_loaded)
      else $error("load while chain cleared");
endmodule : epll_ctrl_asserts
bind epll_ctrl epll_ctrl_asserts u_chk (.clk, .arst_n, .auto_switch_en, .scan_clr, .loop_ref,
   .ref_sel_secondary, .switching, .primary_lost, .locked, .relock_late, .pre_div_m1, .fb_mul_m1,
   .cfg_loaded);
`default_nettype wire

// ### tb/epll_ctrl_bench.sv
// Self-checking bench for the enhanced loop control block
`timescale 1ns/1ps
`default_nettype none
module epll_ctrl_bench;
   import epll_pkg::*;
   typedef struct packed {logic [8:0] pre, fb, pb; logic [3:0] db; logic [10:0] gap;} epll_row_t;
   // Settings rows beside the expected post-tick spacing in clk cycles (ticks every 2 cycles)
   localparam epll_row_t ROWS [4] = '{'{9'h000, 9'h1ff, 9'h003, 4'h1, 11'h008},
      '{9'h1ff, 9'h000, 9'h000, 4'h5, 11'h002}, '{9'h0a5, 9'h05a, 9'h1f6, 4'hb, 11'h3ee},
      '{9'h001, 9'h009, 9'h002, 4'h3, 11'h006}};
   logic clk, arst_n, primary_ref_clock, secondary_ref_clock, pri_en, go, busy;
   logic auto_switch_en, switch_req, osc_tick, scan_clk, scan_data, scan_clr, cfg_loaded;
   logic loop_ref, ref_sel_secondary, switching, primary_lost, pd_up, pd_dn, locked, relock_late;
   logic [CNT_W-1:0] pre_div_m1, fb_mul_m1;
   logic [NUM_POST-1:0][CNT_W-1:0] post_div_m1;
   logic [NUM_POST-1:0][DLY_W-1:0] out_delay;
   logic [NUM_POST-1:0] post_tick, post_clk;
   logic [CHAIN_LEN-1:0] word;
   logic [7:0] nbits;
   int err_count = 0, n_compared = 0, cyc = 0, n_loads = 0, load_cyc = 0, k, t0, nl;
   epll_ctrl #(.SENSE_CYC(32), .LOCK_CNT(2), .RELOCK_CYC(200)) DUT (.clk, .arst_n, .primary_ref_clock,
      .secondary_ref_clock, .auto_switch_en, .switch_req, .osc_tick, .scan_clk, .scan_data, .scan_clr,
      .loop_ref, .ref_sel_secondary, .switching, .primary_lost, .phase_detector_up(pd_up),
      .phase_detector_dn(pd_dn), .locked, .relock_late, .pre_div_m1, .fb_mul_m1, .post_div_m1,
      .out_delay, .cfg_loaded, .post_tick, .post_clk);
   epll_scan_src u_src (.go, .word, .nbits, .scan_clk, .scan_data, .busy);
   // ----------------------------------------------------------------
   // Clocks, oscillator ticks, load monitor and timeout
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Primary can be stopped to model its loss; secondary runs at an unrelated rate
   always #20 primary_ref_clock = pri_en & ~primary_ref_clock;
   always #23 secondary_ref_clock = ~secondary_ref_clock;
   always @(negedge clk) osc_tick <= arst_n & ~osc_tick;
   always @(negedge clk) begin
      if (cfg_loaded === 1'b1) begin
         n_loads++;
         load_cyc = cyc;
      end
   end
   // Ceiling well above the longest expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         stop_test();
      end
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   function automatic logic [CHAIN_LEN-1:0] mk(input epll_row_t r);
      logic [CHAIN_LEN-1:0] w;
      w = '0;
      w[PRE_POS+:CNT_W] = r.pre;
      w[FB_POS+:CNT_W] = r.fb;
      for (int i = 0; i < NUM_POST; i++) begin
         w[POST_POS+CNT_W*i+:CNT_W] = r.pb + 9'(i);
         w[DLY_POS+DLY_W*i+:DLY_W] = r.db + 4'(i);
      end
      return w;
   endfunction : mk
   // Hands a frame to the source model and waits until it has released the pins
   task automatic send(input logic [CHAIN_LEN-1:0] w, input int n);
      word = w;
      nbits = 8'(n);
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      for (k = 0; k < 4000 && busy === 1'b1; k++) @(negedge clk);
      repeat (8) @(negedge clk);
   endtask : send
   task automatic wait_tick();
      for (k = 0; k < 3000 && post_tick[0] !== 1'b1; k++) @(negedge clk);
   endtask : wait_tick
   task automatic rise_ref();
      for (k = 0; k < 50 && loop_ref !== 1'b0; k++) @(negedge clk);
      for (k = 0; k < 50 && loop_ref !== 1'b1; k++) @(negedge clk);
   endtask : rise_ref
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {arst_n, primary_ref_clock, secondary_ref_clock, auto_switch_en, switch_req} = 5'h00;
      {osc_tick, scan_clr, go, word, nbits, pri_en} = '0;
      pri_en = 1'b1;
      repeat (20) @(negedge clk);
      check(16'(pre_div_m1), 16'(CNT_RST));
      check(16'(post_div_m1[9]), 16'(CNT_RST));
      check(16'(out_delay[3]), 16'(DLY_RST));
      check(16'(post_clk), 16'h0000);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      check(16'(post_clk), 16'h03ff);
      // Table of full-chain loads: settings, load time and post divider spacing
      for (int r = 0; r < 4; r++) begin
         t0 = cyc;
         nl = n_loads;
         send(mk(ROWS[r]), CHAIN_LEN);
         check(16'(n_loads - nl), 16'h0001);
         check(16'(load_cyc - t0 < 4000), 16'h0001);
         check(16'(pre_div_m1), 16'(ROWS[r].pre));
         check(16'(fb_mul_m1), 16'(ROWS[r].fb));
         for (int i = 0; i < NUM_POST; i++) begin
            check(16'(post_div_m1[i]), 16'(ROWS[r].pb + 9'(i)));
            check(16'(out_delay[i]), 16'(4'(ROWS[r].db + 4'(i))));
         end
         wait_tick();
         t0 = cyc;
         @(negedge clk);
         wait_tick();
         check(16'(cyc - t0), 16'(ROWS[r].gap));
      end
      // Last row: reference pulses every 16 cycles, feedback every 20, near enough to lock
      for (k = 0; k < 400 && locked !== 1'b1; k++) @(negedge clk);
      check(16'(locked), 16'h0001);
      // Partial frame then clear: leftover bits must not complete the next frame early
      nl = n_loads;
      send(mk(ROWS[0]), 100);
      check(16'(n_loads - nl), 16'h0000);
      scan_clr = 1'b1;
      repeat (4) @(negedge clk);
      scan_clr = 1'b0;
      check(16'(pre_div_m1), 16'(ROWS[3].pre));
      send(mk(ROWS[1]), CHAIN_LEN);
      check(16'(n_loads - nl), 16'h0001);
      check(16'(post_div_m1[5]), 16'(ROWS[1].pb + 9'h005));
      // Feedback by one against a slow reference: one down pulse in every two cycles
      nl = pd_dn;
      @(negedge clk);
      check(16'(nl + pd_dn), 16'h0001);
      // Manual switch there and back
      for (int s = 0; s < 2; s++) begin
         // Unlockable settings: the request goes out as the far side would send it
         switch_req = ~locked;
         for (k = 0; k < 100 && switching !== 1'b1; k++) @(negedge clk);
         for (k = 0; k < 300 && switching === 1'b1; k++) @(negedge clk);
         check(16'(ref_sel_secondary), 16'(1 - s));
         switch_req = 1'b0;
         repeat (10) @(negedge clk);
      end
      repeat (250) @(negedge clk);
      check(16'(relock_late), 16'h0001);
      // Automatic switch on a stopped primary; the loop then follows the secondary period
      auto_switch_en = 1'b1;
      pri_en = 1'b0;
      for (k = 0; k < 500 && ref_sel_secondary !== 1'b1; k++) @(negedge clk);
      check(16'(primary_lost), 16'h0001);
      check(16'(ref_sel_secondary), 16'h0001);
      rise_ref();
      t0 = cyc;
      rise_ref();
      check(16'(cyc - t0 inside {[8:10]}), 16'h0001);
      // Second reset in mid-run returns select and settings
      arst_n = 1'b0;
      repeat (3) @(negedge clk);
      check(16'(ref_sel_secondary), 16'h0000);
      check(16'(fb_mul_m1), 16'(CNT_RST));
      arst_n = 1'b1;
      repeat (10) @(negedge clk);
      stop_test();
   end
endmodule : epll_ctrl_bench
`default_nettype wire
